//--- common/logger_pkg.sv
// constants, field layouts and state codes for the profile record logger
// assumes a single 250 MHz clock domain and a byte-wide storage medium port
// Behaviour
// R1: each profile is a circular, time-ordered record store
// R2: all records of a profile share one size
// R3: record adds 4-byte stamp, 2-byte status, 2-byte check
// R4: stamp is period start in epoch seconds
// R5: stamp leaves only inside a written record
// R6: status is a 16-bit event bit word
// R7: running flags cleared at each period start
// R8: each event merges its flag into running flags
// R9: period end stores flags with the record
// R10: bit0 supply fail, bit1 supply on
// R11: bit2 period lengthened, bit3 period shortened
// R12: bit4 adjusted, bit5 overrun, bit6 invalid data
// R13: bits 7-14 unused, bit15 checksum system error
// R14: period runs between measuring ends or alarms
// R15: check code computed internally, never exposed
// R16: block uses one group, at most four per record
// R17: descriptor holds group, register, field, counts, width
// R18: configuration keeps counts within group limits
// R19: each field stored in bytes-per-field width only
// R20: blocks may differ; size is sum plus overhead
// R21: same record format on every medium
// R22: one profile per setup entry, pools shared freely
// R23: configuration keeps blocks at most 512 bytes
// R24: full profile overwrites oldest, pointer wraps
package logger_pkg;
  localparam int NUM_PROFILES = 4;
  localparam int NUM_BLOCKS = 4;
  localparam int PROF_IDX_W = 2;
  localparam int BLK_CNT_W = 3;
  localparam int ADDR_W = 24;
  localparam int FIELD_W = 32;
  localparam int STAMP_W = 32;
  localparam int STATUS_W = 16;
  localparam int SIZE_W = 16;
  localparam int BYTE_W = 8;
  localparam int BPF_W = 3;
  // byte counts of the fixed record parts
  localparam logic [BPF_W-1:0] STAMP_BYTES = 3'h4;
  localparam logic [BPF_W-1:0] STATUS_BYTES = 3'h2;
  localparam logic [BPF_W-1:0] CHECK_BYTES = 3'h2;
  localparam logic [BPF_W-1:0] LAST_BYTE = 3'h1;
  localparam logic [SIZE_W-1:0] OVERHEAD_BYTES = 16'h0008;
  // status bit positions
  localparam int BIT_SUPPLY_FAIL = 0;
  localparam int BIT_SUPPLY_ON = 1;
  localparam int BIT_PERIOD_LONG = 2;
  localparam int BIT_PERIOD_SHORT = 3;
  localparam int BIT_DATA_ADJUSTED = 4;
  localparam int BIT_DATA_OVERRUN = 5;
  localparam int BIT_DATA_INVALID = 6;
  localparam int BIT_SYSTEM_ERROR = 15;
  // bits 7..14 never set
  localparam logic [STATUS_W-1:0] STATUS_USED_MASK = 16'h807f;
  localparam logic [STATUS_W-1:0] STATUS_CLEAR = 16'h0000;
  // one block descriptor: group, first register, first field, counts, width
  typedef struct packed {
    logic [7:0] gid;
    logic [7:0] firstReg;
    logic [7:0] firstField;
    logic [7:0] regCount;
    logic [7:0] fieldCount;
    logic [BPF_W-1:0] bytesPerField;
  } block_desc_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_BLOCK = 5'h02,
    ST_FETCH = 5'h04,
    ST_EMIT = 5'h08,
    ST_NEXT = 5'h10
  } rec_state_t;
  typedef enum logic [3:0] {
    PH_STAMP = 4'h1,
    PH_DATA = 4'h2,
    PH_STATUS = 4'h4,
    PH_CHECK = 4'h8
  } phase_t;
endpackage

//--- common/status_acc_if.sv
// carrier between the record writer and one running-flags accumulator
// assumes both ends sit on sys_clk
`timescale 1ns/1ns
interface status_acc_if;
  logic [15:0] eventFlags;
  logic capture;
  logic [15:0] flags;
  modport acc (input eventFlags, input capture, output flags);
  modport ctl (output eventFlags, output capture, input flags);
endinterface

//--- rtl/status_accumulator.sv
// running event flags of one profile over its saving period
// assumes events are sys_clk pulses or levels from same-domain logic
`timescale 1ns/1ns
module status_accumulator
  import logger_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // link to the record writer
  status_acc_if.acc bus
);
  logic [STATUS_W-1:0] flags_r;
  logic [STATUS_W-1:0] flags_nxt;

  // events of the capture cycle belong to the new period, none are lost
  always_comb begin
    if (bus.capture) begin
      flags_nxt = STATUS_CLEAR | (bus.eventFlags & STATUS_USED_MASK); // see R7
    end else begin
      flags_nxt = flags_r | (bus.eventFlags & STATUS_USED_MASK); // see R8 R10 R11 R12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_r <= STATUS_CLEAR;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign bus.flags = flags_r;

  a_clear_on_start: // see R7
  assert property (@(posedge sys_clk) disable iff (rst)
    bus.capture |=> flags_r == ($past(bus.eventFlags) & STATUS_USED_MASK))
  else $error("flags not restarted at period start");

  a_flags_merge: // see R8
  assert property (@(posedge sys_clk) disable iff (rst)
    !bus.capture |=> (flags_r & $past(flags_r)) == $past(flags_r)
      && (flags_r & $past(bus.eventFlags) & STATUS_USED_MASK) == ($past(bus.eventFlags) & STATUS_USED_MASK))
  else $error("event flag lost within period");

  a_unused_bits: // see R13
  assert property (@(posedge sys_clk) disable iff (rst)
    (flags_r & ~STATUS_USED_MASK) == STATUS_CLEAR)
  else $error("unused status bit set");
endmodule

//--- rtl/profile_record_logger.sv
// writes one record per saving period into each circular profile
// assumes field reads answer with req/ack and the medium with write/ready handshakes, both on sys_clk
`timescale 1ns/1ns
module profile_record_logger
  import logger_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // period boundaries and time
  input wire logic [logger_pkg::NUM_PROFILES-1:0] measuringEnd,
  input wire logic [logger_pkg::NUM_PROFILES-1:0] internalAlarm,
  input wire logic [logger_pkg::STAMP_W-1:0] epochSeconds,
  // event flags, one 16-bit word per profile
  input wire logic [logger_pkg::NUM_PROFILES-1:0][logger_pkg::STATUS_W-1:0] eventFlags,
  // profile setup entries
  input wire logic cfgDescWrite,
  input wire logic [logger_pkg::PROF_IDX_W-1:0] cfgProfile,
  input wire logic [logger_pkg::BLK_CNT_W-2:0] cfgBlock,
  input wire logger_pkg::block_desc_t cfgDesc,
  input wire logic cfgAreaWrite,
  input wire logic [logger_pkg::ADDR_W-1:0] cfgBase,
  input wire logic [logger_pkg::SIZE_W-1:0] cfgRecords,
  // register group field read
  output logic fieldReq,
  output logic [7:0] fieldGroup,
  output logic [7:0] fieldReg,
  output logic [7:0] fieldIdx,
  input wire logic fieldAck,
  input wire logic [logger_pkg::FIELD_W-1:0] fieldData,
  // storage medium byte writes
  output logic memWrite,
  output logic [logger_pkg::ADDR_W-1:0] memAddr,
  output logic [logger_pkg::BYTE_W-1:0] memData,
  input wire logic memReady,
  // state seen from outside
  output logic busy,
  output logic [logger_pkg::NUM_PROFILES-1:0][logger_pkg::STATUS_W-1:0] runningFlags,
  output logic [logger_pkg::NUM_PROFILES-1:0][logger_pkg::SIZE_W-1:0] writeIndex
);
  localparam int NP = NUM_PROFILES;
  localparam int NB = NUM_BLOCKS;
  localparam logic [BLK_CNT_W-1:0] BLK_END = 3'h4;
  localparam logic [BLK_CNT_W-1:0] BLK_ONE = 3'h1;
  localparam logic [7:0] IDX_ONE = 8'h01;
  localparam logic [SIZE_W-1:0] SIZE_ONE = 16'h0001;

  // sum of block sizes plus the fixed overhead
  function automatic logic [SIZE_W-1:0] recordBytes(input block_desc_t [NB-1:0] d);
    recordBytes = OVERHEAD_BYTES; // see R3
    for (int b = 0; b < NB; b++) begin
      recordBytes = recordBytes + SIZE_W'(d[b].regCount) * SIZE_W'(d[b].fieldCount)
        * SIZE_W'(d[b].bytesPerField); // see R20
    end
  endfunction

  // lowest numbered profile wins when several are waiting
  function automatic logic [PROF_IDX_W-1:0] lowestPending(input logic [NP-1:0] v);
    lowestPending = '0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowestPending = PROF_IDX_W'(i);
      end
    end
  endfunction

  // an empty block takes no bytes and no group read
  function automatic logic blockUsed(input block_desc_t d);
    blockUsed = (d.regCount != 8'h00) && (d.fieldCount != 8'h00) && (d.bytesPerField != 3'h0);
  endfunction

  // running flags, one accumulator per profile
  logic [NP-1:0] periodEnd;
  logic [NP-1:0][STATUS_W-1:0] accFlags;
  status_acc_if accBus[NP] ();

  assign periodEnd = measuringEnd | internalAlarm; // see R14

  for (genvar g = 0; g < NP; g++) begin : g_acc
    assign accBus[g].eventFlags = eventFlags[g];
    assign accBus[g].capture = periodEnd[g]; // see R7
    assign accFlags[g] = accBus[g].flags;
    status_accumulator u_acc (
      .sys_clk(sys_clk),
      .rst(rst),
      .bus(accBus[g])
    );
  end

  assign runningFlags = accFlags;

  // per profile state
  logic [NP-1:0][STAMP_W-1:0] startStamp_r, startStamp_nxt;
  logic [NP-1:0][STAMP_W-1:0] heldStamp_r, heldStamp_nxt;
  logic [NP-1:0][STATUS_W-1:0] heldStatus_r, heldStatus_nxt;
  logic [NP-1:0] pending_r, pending_nxt;
  logic [NP-1:0][SIZE_W-1:0] writePtr_r, writePtr_nxt;
  logic [NP-1:0][ADDR_W-1:0] base_r, base_nxt;
  logic [NP-1:0][SIZE_W-1:0] records_r, records_nxt;
  block_desc_t [NP-1:0][NB-1:0] desc_r, desc_nxt;

  // record writer state
  rec_state_t state_r, state_nxt;
  phase_t phase_r, phase_nxt;
  logic [PROF_IDX_W-1:0] curProf_r, curProf_nxt;
  logic [BLK_CNT_W-1:0] blk_r, blk_nxt;
  logic [7:0] regI_r, regI_nxt;
  logic [7:0] fld_r, fld_nxt;
  logic [BPF_W-1:0] cnt_r, cnt_nxt;
  logic [FIELD_W-1:0] shift_r, shift_nxt;
  logic [STATUS_W-1:0] chk_r, chk_nxt;
  logic [SIZE_W-1:0] off_r, off_nxt;
  logic [ADDR_W-1:0] recBase_r, recBase_nxt;
  logic [STATUS_W-1:0] curStatus_r, curStatus_nxt;
  logic fieldReq_r, fieldReq_nxt;
  logic [7:0] fieldGroup_r, fieldGroup_nxt;
  logic [7:0] fieldReg_r, fieldReg_nxt;
  logic [7:0] fieldIdx_r, fieldIdx_nxt;
  logic memWrite_r, memWrite_nxt;
  logic [ADDR_W-1:0] memAddr_r, memAddr_nxt;
  logic [BYTE_W-1:0] memData_r, memData_nxt;
  logic busy_r, busy_nxt;
  logic recStart;
  logic recDone;
  block_desc_t curDesc;
  block_desc_t nextDesc;
  logic [PROF_IDX_W-1:0] pick;

  assign pick = lowestPending(pending_r);
  assign curDesc = desc_r[curProf_r][blk_r[BLK_CNT_W-2:0]];

  // per profile: period stamps, held status, circular pointer, setup
  always_comb begin
    startStamp_nxt = startStamp_r;
    heldStamp_nxt = heldStamp_r;
    heldStatus_nxt = heldStatus_r;
    pending_nxt = pending_r;
    writePtr_nxt = writePtr_r;
    base_nxt = base_r;
    records_nxt = records_r;
    desc_nxt = desc_r;
    for (int p = 0; p < NP; p++) begin
      // taking a record clears its request, a new period end the same cycle wins
      if (recStart && pick == PROF_IDX_W'(p)) begin
        pending_nxt[p] = 1'b0;
      end
      if (periodEnd[p]) begin
        heldStamp_nxt[p] = startStamp_r[p]; // see R4
        heldStatus_nxt[p] = accFlags[p]; // see R9
        startStamp_nxt[p] = epochSeconds; // see R4
        pending_nxt[p] = 1'b1; // see R1
      end
      // oldest record is overwritten once the ring is full
      if (recDone && curProf_r == PROF_IDX_W'(p)) begin
        if (writePtr_r[p] + SIZE_ONE >= records_r[p]) begin
          writePtr_nxt[p] = '0; // see R24
        end else begin
          writePtr_nxt[p] = writePtr_r[p] + SIZE_ONE; // see R1
        end
      end
    end
    if (cfgDescWrite) begin
      desc_nxt[cfgProfile][cfgBlock] = cfgDesc; // see R17
    end
    // moving a profile's area restarts its ring
    if (cfgAreaWrite) begin
      base_nxt[cfgProfile] = cfgBase; // see R22
      records_nxt[cfgProfile] = cfgRecords;
      writePtr_nxt[cfgProfile] = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      startStamp_r <= '0;
      heldStamp_r <= '0;
      heldStatus_r <= '0;
      pending_r <= '0;
      writePtr_r <= '0;
      base_r <= '0;
      records_r <= '0;
      desc_r <= '0;
    end else begin
      startStamp_r <= startStamp_nxt;
      heldStamp_r <= heldStamp_nxt;
      heldStatus_r <= heldStatus_nxt;
      pending_r <= pending_nxt;
      writePtr_r <= writePtr_nxt;
      base_r <= base_nxt;
      records_r <= records_nxt;
      desc_r <= desc_nxt;
    end
  end

  // record writer: stamp, data fields, status, check code, bytes low first
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    curProf_nxt = curProf_r;
    blk_nxt = blk_r;
    regI_nxt = regI_r;
    fld_nxt = fld_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    chk_nxt = chk_r;
    off_nxt = off_r;
    recBase_nxt = recBase_r;
    curStatus_nxt = curStatus_r;
    recStart = 1'b0;
    recDone = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (|pending_r) begin
          recStart = 1'b1;
          curProf_nxt = pick;
          curStatus_nxt = heldStatus_r[pick]; // see R9
          shift_nxt = heldStamp_r[pick]; // see R5
          cnt_nxt = STAMP_BYTES; // see R3
          phase_nxt = PH_STAMP;
          chk_nxt = '0;
          off_nxt = '0;
          // fixed record size makes the slot address a plain product
          recBase_nxt = base_r[pick] + ADDR_W'(writePtr_r[pick]) * ADDR_W'(recordBytes(desc_r[pick])); // see R2
          state_nxt = ST_EMIT;
        end
      end
      ST_BLOCK: begin
        if (blk_r == BLK_END) begin
          phase_nxt = PH_STATUS;
          shift_nxt = {16'h0000, curStatus_r}; // see R6
          cnt_nxt = STATUS_BYTES;
          state_nxt = ST_EMIT;
        end else if (blockUsed(curDesc)) begin
          regI_nxt = '0;
          fld_nxt = '0;
          state_nxt = ST_FETCH; // see R16
        end else begin
          blk_nxt = blk_r + BLK_ONE;
        end
      end
      ST_FETCH: begin
        if (fieldAck) begin
          shift_nxt = fieldData;
          cnt_nxt = curDesc.bytesPerField; // see R19
          state_nxt = ST_EMIT;
        end
      end
      ST_EMIT: begin
        // the check code covers every byte before it
        if (memReady) begin
          chk_nxt = chk_r + {8'h00, shift_r[BYTE_W-1:0]}; // see R15
          shift_nxt = shift_r >> BYTE_W;
          cnt_nxt = cnt_r - LAST_BYTE;
          off_nxt = off_r + SIZE_ONE;
          if (cnt_r == LAST_BYTE) begin
            state_nxt = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        unique case (phase_r)
          PH_STAMP: begin
            phase_nxt = PH_DATA;
            blk_nxt = '0;
            state_nxt = ST_BLOCK;
          end
          PH_DATA: begin
            if (fld_r + IDX_ONE < curDesc.fieldCount) begin
              fld_nxt = fld_r + IDX_ONE;
              state_nxt = ST_FETCH;
            end else if (regI_r + IDX_ONE < curDesc.regCount) begin
              regI_nxt = regI_r + IDX_ONE;
              fld_nxt = '0;
              state_nxt = ST_FETCH;
            end else begin
              blk_nxt = blk_r + BLK_ONE;
              state_nxt = ST_BLOCK;
            end
          end
          PH_STATUS: begin
            phase_nxt = PH_CHECK;
            shift_nxt = {16'h0000, chk_r}; // see R15
            cnt_nxt = CHECK_BYTES;
            state_nxt = ST_EMIT;
          end
          PH_CHECK: begin
            recDone = 1'b1;
            state_nxt = ST_IDLE;
          end
        endcase
      end
    endcase
  end

  // port outputs follow the next state so they stand with it
  assign nextDesc = desc_r[curProf_nxt][blk_nxt[BLK_CNT_W-2:0]];

  always_comb begin
    fieldReq_nxt = (state_nxt == ST_FETCH);
    fieldGroup_nxt = nextDesc.gid;
    fieldReg_nxt = nextDesc.firstReg + regI_nxt;
    fieldIdx_nxt = nextDesc.firstField + fld_nxt;
    memWrite_nxt = (state_nxt == ST_EMIT); // see R21
    memAddr_nxt = recBase_nxt + ADDR_W'(off_nxt);
    memData_nxt = shift_nxt[BYTE_W-1:0];
    busy_nxt = (state_nxt != ST_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      phase_r <= PH_STAMP;
      curProf_r <= '0;
      blk_r <= '0;
      regI_r <= '0;
      fld_r <= '0;
      cnt_r <= '0;
      shift_r <= '0;
      chk_r <= '0;
      off_r <= '0;
      recBase_r <= '0;
      curStatus_r <= '0;
      fieldReq_r <= 1'b0;
      fieldGroup_r <= '0;
      fieldReg_r <= '0;
      fieldIdx_r <= '0;
      memWrite_r <= 1'b0;
      memAddr_r <= '0;
      memData_r <= '0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      curProf_r <= curProf_nxt;
      blk_r <= blk_nxt;
      regI_r <= regI_nxt;
      fld_r <= fld_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      chk_r <= chk_nxt;
      off_r <= off_nxt;
      recBase_r <= recBase_nxt;
      curStatus_r <= curStatus_nxt;
      fieldReq_r <= fieldReq_nxt;
      fieldGroup_r <= fieldGroup_nxt;
      fieldReg_r <= fieldReg_nxt;
      fieldIdx_r <= fieldIdx_nxt;
      memWrite_r <= memWrite_nxt;
      memAddr_r <= memAddr_nxt;
      memData_r <= memData_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign fieldReq = fieldReq_r;
  assign fieldGroup = fieldGroup_r;
  assign fieldReg = fieldReg_r;
  assign fieldIdx = fieldIdx_r;
  assign memWrite = memWrite_r;
  assign memAddr = memAddr_r;
  assign memData = memData_r;
  assign busy = busy_r;
  assign writeIndex = writePtr_r;

  a_stamp_first: // see R4
  assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_IDLE && |pending_r) |=> memWrite_r
      && memData_r == $past(heldStamp_r[lowestPending(pending_r)][BYTE_W-1:0]))
  else $error("record does not open with the period stamp");

  a_status_held: // see R9
  assert property (@(posedge sys_clk) disable iff (rst)
    periodEnd[0] |=> heldStatus_r[0] == $past(accFlags[0]) && pending_r[0])
  else $error("period status not held at period end");

  a_record_size: // see R2
  assert property (@(posedge sys_clk) disable iff (rst)
    recDone |-> off_r == recordBytes(desc_r[curProf_r]))
  else $error("record length differs from profile record size");

  a_field_width: // see R19
  assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_FETCH && fieldAck) |=> memWrite_r
      && memData_r == $past(fieldData[BYTE_W-1:0]) && cnt_r == $past(curDesc.bytesPerField))
  else $error("field not stored at configured width");

  a_check_emit: // see R15
  assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_NEXT && phase_r == PH_STATUS) |=> memWrite_r && memData_r == $past(chk_r[BYTE_W-1:0]))
  else $error("check code byte wrong");

  a_ring_wrap: // see R24
  assert property (@(posedge sys_clk) disable iff (rst)
    (recDone && !cfgAreaWrite && writePtr_r[curProf_r] + SIZE_ONE >= records_r[curProf_r])
      |=> writePtr_r[$past(curProf_r)] == '0)
  else $error("write pointer did not wrap");

  a_start_soon: // see R14
  assert property (@(posedge sys_clk) disable iff (rst)
    (periodEnd != '0 && state_r == ST_IDLE) |=> ##1 (busy_r && memWrite_r))
  else $error("period end did not start a record");
endmodule

//--- bench/medium_model.sv
// far-side model: register group field source and byte-wide storage medium
// assumes the logger's req/ack and write/ready handshakes on sys_clk
`timescale 1ns/1ns
module medium_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pacing from the bench
  input wire logic slow,
  // register group field read
  input wire logic fieldReq,
  input wire logic [7:0] fieldGroup,
  input wire logic [7:0] fieldReg,
  input wire logic [7:0] fieldIdx,
  output logic fieldAck,
  output logic [31:0] fieldData,
  // storage medium byte writes
  input wire logic memWrite,
  output logic memReady
);
  logic [3:0] cycleCnt_r;
  logic [31:0] fieldVal;

  // field value is built from its own address so every byte is traceable
  assign fieldVal = {fieldGroup, fieldReg, fieldIdx, 8'h5a ^ fieldIdx};
  // outside the ack cycle the data bus shows garbage, not the last value
  assign fieldData = fieldAck ? fieldVal : ~fieldVal;
  // slow mode accepts one byte in four; the record must not depend on pacing
  assign memReady = !slow || (cycleCnt_r[1:0] == 2'h3);

  // ack is one pulse; the !fieldAck term avoids a second ack while req drops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cycleCnt_r <= 4'h0;
      fieldAck <= 1'b0;
    end else begin
      cycleCnt_r <= cycleCnt_r + 4'h1;
      fieldAck <= fieldReq && !fieldAck && (!slow || cycleCnt_r[1:0] == 2'h0);
    end
  end
endmodule

//--- bench/profile_record_logger_tb_top.sv
// self-checking bench for the profile record logger
// assumes medium_model on the far side and logger_pkg constants
`timescale 1ns/1ns
module profile_record_logger_tb_top;
  import logger_pkg::*;
  logic sys_clk, rst, slow, cfgDescWrite, cfgAreaWrite;
  logic [NUM_PROFILES-1:0] measuringEnd, internalAlarm;
  logic [STAMP_W-1:0] epochSeconds;
  logic [NUM_PROFILES-1:0][STATUS_W-1:0] eventFlags, runningFlags;
  logic [PROF_IDX_W-1:0] cfgProfile;
  logic [BLK_CNT_W-2:0] cfgBlock;
  block_desc_t cfgDesc;
  logic [ADDR_W-1:0] cfgBase, memAddr;
  logic [SIZE_W-1:0] cfgRecords;
  logic fieldReq, fieldAck, memWrite, memReady, busy;
  logic [7:0] fieldGroup, fieldReg, fieldIdx, memData;
  logic [FIELD_W-1:0] fieldData;
  logic [NUM_PROFILES-1:0][SIZE_W-1:0] writeIndex;
  int error_cnt, n_tests;
  logic [31:0] seed;
  block_desc_t descTab [4][4];
  logic [ADDR_W-1:0] baseTab [4];
  logic [SIZE_W-1:0] recTab [4], idxTab [4];
  logic [STAMP_W-1:0] startTab [4];
  logic [STATUS_W-1:0] accTab [4];
  logic [31:0] expQ [$];

  profile_record_logger profile_record_logger_i (.sys_clk, .rst, .measuringEnd, .internalAlarm, .epochSeconds,
    .eventFlags, .cfgDescWrite, .cfgProfile, .cfgBlock, .cfgDesc, .cfgAreaWrite, .cfgBase, .cfgRecords,
    .fieldReq, .fieldGroup, .fieldReg, .fieldIdx, .fieldAck, .fieldData, .memWrite, .memAddr, .memData,
    .memReady, .busy, .runningFlags, .writeIndex);
  medium_model medium_model_i (.sys_clk, .rst, .slow, .fieldReq, .fieldGroup, .fieldReg, .fieldIdx,
    .fieldAck, .fieldData, .memWrite, .memReady);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // record length from the bench's own copy of the descriptors
  function automatic logic [15:0] rec_size(input int p);
    block_desc_t d;
    rec_size = 16'h0008;
    for (int b = 0; b < 4; b++) begin
      d = descTab[p][b];
      rec_size += 16'(d.regCount) * 16'(d.fieldCount) * 16'(d.bytesPerField);
    end
  endfunction
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (exp !== got) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input int p, inout int off, inout logic [15:0] sum, input logic [7:0] b);
    expQ.push_back({ADDR_W'(baseTab[p] + idxTab[p] * rec_size(p) + off), b});
    off++;
    sum += 16'(b);
  endtask
  // notes every byte the held record must produce, in medium order
  task automatic push_rec(input int p);
    int off;
    logic [15:0] sum, cs, st;
    logic [31:0] v;
    block_desc_t d;
    off = 0;
    sum = 16'h0000;
    for (int k = 0; k < 4; k++) put(p, off, sum, startTab[p][8*k+:8]);
    for (int b = 0; b < 4; b++) begin
      d = descTab[p][b];
      for (int r = 0; r < d.regCount; r++)
        for (int f = 0; f < d.fieldCount; f++) begin
          v = {d.gid, 8'(d.firstReg + r), 8'(d.firstField + f), 8'h5a ^ 8'(d.firstField + f)};
          for (int k = 0; k < d.bytesPerField; k++) put(p, off, sum, 8'(v >> (8 * k)));
        end
    end
    st = accTab[p] & STATUS_USED_MASK;
    put(p, off, sum, st[7:0]);
    put(p, off, sum, st[15:8]);
    cs = sum;
    put(p, off, sum, cs[7:0]);
    put(p, off, sum, cs[15:8]);
    idxTab[p] = (idxTab[p] + 16'h0001 >= recTab[p]) ? 16'h0000 : idxTab[p] + 16'h0001;
  endtask
  // config stays within group limits and 512-byte blocks
  task automatic set_desc(input int p, input int b, input block_desc_t d);
    cfgProfile = PROF_IDX_W'(p);
    cfgBlock = 2'(b);
    cfgDesc = d;
    cfgDescWrite = 1'b1;
    descTab[p][b] = d;
    tick();
    cfgDescWrite = 1'b0;
    tick();
  endtask
  task automatic set_area(input int p, input logic [23:0] base, input logic [15:0] n);
    cfgProfile = PROF_IDX_W'(p);
    cfgBase = base;
    cfgRecords = n;
    cfgAreaWrite = 1'b1;
    baseTab[p] = base;
    recTab[p] = n;
    idxTab[p] = 16'h0000;
    tick();
    cfgAreaWrite = 1'b0;
    tick();
  endtask
  task automatic event_on(input int p, input logic [15:0] v);
    eventFlags[p] = v;
    accTab[p] |= v;
    tick();
    eventFlags[p] = 16'h0000;
    check("runningFlags", accTab[p] & STATUS_USED_MASK, runningFlags[p]);
    tick();
  endtask
  // an event set by the caller in this cycle belongs to the new period
  task automatic period_end(input logic [3:0] me, input logic [3:0] al, input logic [31:0] now);
    for (int p = 0; p < 4; p++) if (me[p] | al[p]) push_rec(p);
    measuringEnd = me;
    internalAlarm = al;
    epochSeconds = now;
    for (int p = 0; p < 4; p++)
      if (me[p] | al[p]) begin
        startTab[p] = now;
        accTab[p] = eventFlags[p];
      end
    tick();
    measuringEnd = 4'h0;
    internalAlarm = 4'h0;
    for (int p = 0; p < 4; p++)
      if (me[p] | al[p]) check("runningFlags", accTab[p] & STATUS_USED_MASK, runningFlags[p]);
  endtask
  task automatic wait_idle(input string name);
    int n;
    n = 0;
    tick();
    while ((busy !== 1'b0 || expQ.size() != 0) && n < 3000) begin
      tick();
      n++;
    end
    check("idle", 32'h1, 32'(n < 3000));
    for (int p = 0; p < 4; p++) check("writeIndex", 32'(idxTab[p]), 32'(writeIndex[p]));
    $display("test %s done", name);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // each accepted byte is matched against the oldest note
  always @(negedge sys_clk) begin
    if (memWrite === 1'b1 && memReady === 1'b1) begin
      if (expQ.size() == 0) begin
        error_cnt++;
        $display("CHECK FAILED memByte expected none seen %h", memAddr);
      end else check("memByte", expQ.pop_front(), {memAddr, memData});
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // cut a hang well past the longest expected run
  initial begin
    #200000;
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    {rst, slow, cfgDescWrite, cfgAreaWrite, measuringEnd, internalAlarm} = '0;
    {epochSeconds, eventFlags, cfgProfile, cfgBlock, cfgDesc, cfgBase, cfgRecords} = '0;
    error_cnt = 0;
    n_tests = 0;
    seed = 32'h6b55c919;
    foreach (baseTab[p]) {baseTab[p], recTab[p], idxTab[p], startTab[p], accTab[p]} = '0;
    foreach (descTab[p, b]) descTab[p][b] = '0;
    rst = 1'b1;
    repeat (4) tick();
    rst = 1'b0;
    // one block, unused status bits offered, first stamp is zero
    set_desc(0, 0, {8'h10, 8'h02, 8'h01, 8'h02, 8'h02, 3'h2});
    set_area(0, 24'h000100, 16'h0002);
    event_on(0, 16'h0001);
    event_on(0, 16'hff82);
    period_end(4'h1, 4'h0, 32'h5f000000);
    wait_idle("single_block");
    // alarm end with a coincident event, stalling medium, then slot wrap
    slow = 1'b1;
    for (int i = 0; i < 2; i++) begin
      event_on(0, 16'h0004);
      eventFlags[0] = 16'h0008;
      period_end(4'h0, 4'h1, 32'h5f000384 + 32'(i));
      eventFlags[0] = 16'h0000;
      wait_idle("alarm_wrap");
    end
    // mixed block sizes, skipped block, wide field, two profiles together
    set_desc(1, 0, {8'h21, 8'h00, 8'h03, 8'h01, 8'h03, 3'h1});
    set_desc(1, 1, {8'h22, 8'h01, 8'h00, 8'h00, 8'h02, 3'h2});
    set_desc(1, 2, {8'h23, 8'h04, 8'h00, 8'h02, 8'h01, 3'h4});
    set_desc(1, 3, {8'h24, 8'h07, 8'h05, 8'h01, 8'h01, 3'h5});
    set_desc(2, 0, {8'h30, 8'h09, 8'h02, 8'h01, 8'h02, 3'h3});
    set_area(1, 24'h001000, 16'h0003);
    set_area(2, 24'h002000, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      event_on(1, seed[15:0]);
      event_on(2, seed[31:16]);
      period_end(4'h2, 4'h4, seed);
      wait_idle("mixed_blocks");
      slow = 1'b0;
    end
    // every status bit alone, overhead-only records wrapping over four slots
    set_area(3, 24'hfff000, 16'h0004);
    for (int k = 0; k < 16; k++) begin
      event_on(3, 16'h0001 << k);
      seed = lfsr(seed);
      slow = seed[0];
      period_end(4'h8, 4'h0, seed);
      wait_idle("status_bits");
    end
    final_report();
  end
endmodule
